// [rtl/test_mux_device.sv]
/*
 * Device end: configuration registers for the skew test multiplexer,
 * dynamic linearization and temperature diode, and the test pin driver.
 * Assumes the host drives the register port and LVDS pins on clk_in.
 */
// Functional notes
// - enabled mux drives selected input onto test pair
// - software never enables mux and diode together
// - pair select lives in bits 5 to 1
// - side 0 second signal, side 1 inverted first
// - 0x60 routes port B top bit
// - 0x61 shows inverted data clock
// - 16-bit port A pairs step down, then clock
// - port B pairs start with clock, step down
// - narrower variants start high, missing addresses empty
// - mux control resets to zero
// - software keeps mux disabled in normal use
// - host drives alternating skew patterns
// - linearizer disable at bit 0
// - three-bit gain field in bits 3 to 1
// - upper voltage code bits 3 to 0, reset 1000
// - lower voltage code bits 7 to 4, reset 0000
// - software keeps upper above lower
// - linearizer registers reset 0x00 and 0x08
// - diode mode picks unbiased or biased diode
// - diode enable bit 0 own register, resets zero
`timescale 1ns/1ps
`include "test_mux_regs.svh"

module test_mux_device #(
    parameter int RESOLUTION = 16
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    test_port_if.device     port,
    output logic            linearizer_disable_out,
    output logic [2:0]      linearizer_gain_out,
    output logic [3:0]      linearizer_upper_voltage_out,
    output logic [3:0]      linearizer_lower_voltage_out,
    output logic            temp_diode_connect_out,
    output logic            temp_diode_mode_out,
    output logic            window_order_error_out
);
    // ****************************************************************
    // register storage
    // ****************************************************************
    test_mux_pkg::reg_byte_t lin_ctrl_q;
    test_mux_pkg::reg_byte_t lin_ctrl_d;
    test_mux_pkg::reg_byte_t lin_window_q;
    test_mux_pkg::reg_byte_t lin_window_d;
    test_mux_pkg::reg_byte_t mux_ctrl_q;
    test_mux_pkg::reg_byte_t mux_ctrl_d;
    test_mux_pkg::reg_byte_t diode_ctrl_q;
    test_mux_pkg::reg_byte_t diode_ctrl_d;
    test_mux_pkg::reg_byte_t rdata_q;
    test_mux_pkg::reg_byte_t rdata_d;
    logic                    ack_q;
    logic                    test_p_q;
    logic                    test_n_q;
    logic                    test_oe_n_q;
    logic                    test_oe_n_d;

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire hit_lin_ctrl   = (port.reg_addr == `LIN_CTRL_OFFSET);
    wire hit_lin_window = (port.reg_addr == `LIN_WINDOW_OFFSET);
    wire hit_mux_ctrl   = (port.reg_addr == `MUX_CTRL_OFFSET);
    wire hit_diode_ctrl = (port.reg_addr == `DIODE_CTRL_OFFSET);
    wire wr_lin_ctrl    = port.reg_wr && hit_lin_ctrl;
    wire wr_lin_window  = port.reg_wr && hit_lin_window;
    wire wr_mux_ctrl    = port.reg_wr && hit_mux_ctrl;
    wire wr_diode_ctrl  = port.reg_wr && hit_diode_ctrl;

    // writes land at the strobe edge itself, with no wait state
    // reserved bits never store, so they always read back as zero
    assign lin_ctrl_d   = wr_lin_ctrl   ? (port.reg_wdata & 8'h0F) : lin_ctrl_q;
    assign lin_window_d = wr_lin_window ? port.reg_wdata : lin_window_q;
    assign mux_ctrl_d   = wr_mux_ctrl   ? (port.reg_wdata & 8'h7F) : mux_ctrl_q;
    assign diode_ctrl_d = wr_diode_ctrl ? (port.reg_wdata & 8'h03) : diode_ctrl_q;

    // ****************************************************************
    // read back; unmapped offsets read as zero but still answer
    // ****************************************************************
    always_comb begin
        if (hit_lin_ctrl) begin
            rdata_d = lin_ctrl_q;
        end else if (hit_lin_window) begin
            rdata_d = lin_window_q;
        end else if (hit_mux_ctrl) begin
            rdata_d = mux_ctrl_q;
        end else if (hit_diode_ctrl) begin
            rdata_d = diode_ctrl_q;
        end else begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lin_ctrl_q   <= `LIN_CTRL_RESET;
            lin_window_q <= `LIN_WINDOW_RESET;
        end else begin
            lin_ctrl_q   <= lin_ctrl_d;
            lin_window_q <= lin_window_d;
        end
    end

    // pin owners clear on reset, so the test pair starts floating
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mux_ctrl_q   <= `MUX_CTRL_RESET;
            diode_ctrl_q <= `DIODE_CTRL_RESET;
        end else begin
            mux_ctrl_q   <= mux_ctrl_d;
            diode_ctrl_q <= diode_ctrl_d;
        end
    end

    // ack one cycle after every strobe; read data held until the next
    // read so a slow host can still pick it up
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q      <= 8'h00;
            ack_q        <= 1'b0;
        end else begin
            rdata_q      <= port.reg_rd ? rdata_d : rdata_q;
            ack_q        <= port.reg_wr || port.reg_rd;
        end
    end

    assign port.reg_rdata = rdata_q;
    assign port.reg_ack   = ack_q;

    // ****************************************************************
    // field views
    // ****************************************************************
    wire       test_mux_enable   = mux_ctrl_q[`MUX_ENABLE_BIT];
    wire [4:0] test_pair_select  = mux_ctrl_q[`MUX_PAIR_MSB:`MUX_PAIR_LSB];
    wire       test_side_select  = mux_ctrl_q[`MUX_SIDE_BIT];
    wire       temp_diode_enable = diode_ctrl_q[`DIODE_ENABLE_BIT];
    wire       temp_diode_mode   = diode_ctrl_q[`DIODE_MODE_BIT];

    // ****************************************************************
    // pair selection and test pin driver
    // ****************************************************************
    logic selected_valid;
    logic selected_signal;

    pair_select_decoder #(
        .RESOLUTION (RESOLUTION)
    ) u_decoder (
        .pair_in    (test_pair_select),
        .side_in    (test_side_select),
        .clock_in   (port.data_clock_input),
        .port_a_in  (port.port_a_data_inputs),
        .port_b_in  (port.port_b_data_inputs),
        .valid_out  (selected_valid),
        .signal_out (selected_signal)
    );

    // an empty address leaves the pins floating rather than driving a
    // constant that could be mistaken for a stuck input
    assign test_oe_n_d = !(test_mux_enable && selected_valid);

    // registered drive costs one cycle of latency; skew between two
    // neighbours is still comparable since both take the same path
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            test_p_q    <= 1'b0;
            test_n_q    <= 1'b1;
        end else begin
            test_p_q    <= selected_signal;
            test_n_q    <= ~selected_signal;
        end
    end

    // enable kept apart from the data; it must float through reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            test_oe_n_q <= 1'b1;
        end else begin
            test_oe_n_q <= test_oe_n_d;
        end
    end

    assign port.test_p    = test_p_q;
    assign port.test_n    = test_n_q;
    assign port.test_oe_n = test_oe_n_q;

    // ****************************************************************
    // linearizer and diode controls
    // ****************************************************************
    assign linearizer_disable_out       = lin_ctrl_q[`LIN_DISABLE_BIT];
    assign linearizer_gain_out          = lin_ctrl_q[`LIN_GAIN_MSB:`LIN_GAIN_LSB];
    assign linearizer_upper_voltage_out = lin_window_q[`LIN_UPPER_MSB:`LIN_UPPER_LSB];
    assign linearizer_lower_voltage_out = lin_window_q[`LIN_LOWER_MSB:`LIN_LOWER_LSB];

    // mux wins the shared pins if software sets both enables
    // the clash itself is not reported back to software
    assign temp_diode_connect_out = temp_diode_enable && !test_mux_enable;
    assign temp_diode_mode_out    = temp_diode_mode;

    // flags a window that software has programmed out of order
    // advisory only: the linearizer runs on regardless
    assign window_order_error_out = (linearizer_upper_voltage_out
                                     <= linearizer_lower_voltage_out);
endmodule

// [rtl/test_mux_regs.svh]
/*
 * Register offsets, field positions, reset values and codes shared by the
 * skew test multiplexer device end and its host controller.
 * Assumes nothing; definitions only.
 */
`ifndef TEST_MUX_REGS_SVH
`define TEST_MUX_REGS_SVH

// ****************************************************************
// device register map (8-bit registers, 8-bit offsets)
// ****************************************************************
`define LIN_CTRL_OFFSET       8'h07
`define LIN_WINDOW_OFFSET     8'h08
`define MUX_CTRL_OFFSET       8'h18
`define DIODE_CTRL_OFFSET     8'h19

`define LIN_CTRL_RESET        8'h00
`define LIN_WINDOW_RESET      8'h08
`define MUX_CTRL_RESET        8'h00
`define DIODE_CTRL_RESET      8'h00

`define LIN_DISABLE_BIT       0
`define LIN_GAIN_LSB          1
`define LIN_GAIN_MSB          3
`define LIN_UPPER_LSB         0
`define LIN_UPPER_MSB         3
`define LIN_LOWER_LSB         4
`define LIN_LOWER_MSB         7
`define MUX_SIDE_BIT          0
`define MUX_PAIR_LSB          1
`define MUX_PAIR_MSB          5
`define MUX_ENABLE_BIT        6
`define DIODE_ENABLE_BIT      0
`define DIODE_MODE_BIT        1

`define PAIR_CODE_CLOCK       5'h0F
`define PAIR_CODE_B_TOP       5'h10

// ****************************************************************
// host controller register map (Avalon-MM byte addresses)
// ****************************************************************
`define HOST_CMD_ADDR         4'h0
`define HOST_STATUS_ADDR      4'h4
`define HOST_PATTERN_ADDR     4'h8
`define HOST_CMD_READ_BIT     16
`define HOST_PATTERN_EN_BIT   0

// alternating skew patterns per resolution
`define PATTERN16_LO          16'h5555
`define PATTERN16_HI          16'hAAAA
`define PATTERN14_LO          16'h1555
`define PATTERN14_HI          16'h2AAA
`define PATTERN11_LO          16'h0555
`define PATTERN11_HI          16'h02AA

`endif

// [rtl/test_mux_pkg.sv]
/*
 * Types shared by the skew test multiplexer ends.
 * Assumes the constants header for field positions.
 */
package test_mux_pkg;

    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_ISSUE,
        HOST_WAIT
    } host_state_t;

    typedef logic [7:0] reg_byte_t;

endpackage

// [rtl/test_port_if.sv]
/*
 * Carrier between the host controller and the device end: a byte-wide
 * register port, the LVDS-side data pins and the differential test pins.
 * Assumes both ends share clk_in.
 */
`timescale 1ns/1ps

interface test_port_if;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        reg_ack;
    logic        data_clock_input;
    logic [15:0] port_a_data_inputs;
    logic [15:0] port_b_data_inputs;
    logic        test_p;
    logic        test_n;
    logic        test_oe_n;

    modport device (
        input  reg_addr, reg_wdata, reg_wr, reg_rd,
        input  data_clock_input, port_a_data_inputs, port_b_data_inputs,
        output reg_rdata, reg_ack, test_p, test_n, test_oe_n
    );

    modport host (
        output reg_addr, reg_wdata, reg_wr, reg_rd,
        output data_clock_input, port_a_data_inputs, port_b_data_inputs,
        input  reg_rdata, reg_ack, test_p, test_n, test_oe_n
    );
endinterface

// [rtl/pair_select_decoder.sv]
/*
 * Maps a pair-select code and side bit onto one LVDS input, for a
 * device resolution of 16, 14 or 11 bits.
 * Assumes inputs are already in the clk_in domain; purely combinational.
 */
`timescale 1ns/1ps
`include "test_mux_regs.svh"

module pair_select_decoder #(
    parameter int RESOLUTION = 16
) (
    input  wire logic [4:0]  pair_in,
    input  wire logic        side_in,
    input  wire logic        clock_in,
    input  wire logic [15:0] port_a_in,
    input  wire logic [15:0] port_b_in,
    output logic             valid_out,
    output logic             signal_out
);
    // signed index arithmetic: a negative index means "no such bit"
    logic signed [6:0] code_low;
    logic signed [6:0] idx;
    logic [15:0]       port;

    always_comb begin
        code_low   = {3'h0, pair_in[3:0]};
        idx        = 7'sd0;
        port       = pair_in[4] ? port_b_in : port_a_in;
        valid_out  = 1'b0;
        signal_out = 1'b0;
        if (pair_in == `PAIR_CODE_CLOCK) begin
            // only the widest variant pairs the clock with port A bit 0
            valid_out  = !side_in || (RESOLUTION == 16);
            signal_out = side_in ? ~port_a_in[0] : clock_in;
        end else if (pair_in == `PAIR_CODE_B_TOP) begin
            valid_out  = 1'b1;
            signal_out = side_in ? ~clock_in : port_b_in[RESOLUTION-1];
        end else begin
            if (pair_in[4]) begin
                idx = 7'(RESOLUTION - 1) - code_low;
            end else begin
                idx = 7'(RESOLUTION - 2) - code_low;
            end
            if (side_in) begin
                valid_out  = (idx >= -7'sd1);
                signal_out = (idx >= -7'sd1) ? ~port[4'(idx + 7'sd1)] : 1'b0;
            end else begin
                valid_out  = (idx >= 7'sd0);
                signal_out = (idx >= 7'sd0) ? port[4'(idx)] : 1'b0;
            end
        end
    end
endmodule

// [rtl/test_mux_host.sv]
/*
 * Host end: Avalon-MM slave that forwards register accesses to the device
 * and drives the alternating skew pattern on the LVDS data pins.
 * Assumes one clock shared with the device end.
 */
`timescale 1ns/1ps
`include "test_mux_regs.svh"

module test_mux_host #(
    parameter int RESOLUTION = 16
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    test_port_if.host        port
);
    // ****************************************************************
    // decode
    // ****************************************************************
    test_mux_pkg::host_state_t state_q;
    test_mux_pkg::host_state_t state_d;
    logic [7:0]  addr_q;
    logic [7:0]  wdata_q;
    logic        is_read_q;
    logic [7:0]  rdata_q;
    logic        pattern_en_q;
    logic        phase_q;
    logic        done_q;
    logic [31:0] readdata_q;

    wire busy        = (state_q != test_mux_pkg::HOST_IDLE);
    wire sel_cmd     = (avs_address_in == `HOST_CMD_ADDR);
    wire sel_status  = (avs_address_in == `HOST_STATUS_ADDR);
    wire sel_pattern = (avs_address_in == `HOST_PATTERN_ADDR);
    // a command write stalls until the previous transfer is finished
    wire cmd_stall   = avs_write_in && sel_cmd && busy;
    wire accept      = (avs_read_in || avs_write_in) && !done_q && !cmd_stall;
    // writes act only at the edge that sees waitrequest low
    wire take_write  = avs_write_in && done_q;
    wire start       = take_write && sel_cmd;

    // one wait cycle on every access not stalled; answer lands on the second edge
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !done_q;

    wire [15:0] pattern_lo = (RESOLUTION == 16) ? `PATTERN16_LO :
                             (RESOLUTION == 14) ? `PATTERN14_LO : `PATTERN11_LO;
    wire [15:0] pattern_hi = (RESOLUTION == 16) ? `PATTERN16_HI :
                             (RESOLUTION == 14) ? `PATTERN14_HI : `PATTERN11_HI;

    // ****************************************************************
    // transfer sequencer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            test_mux_pkg::HOST_IDLE: begin
                if (start) begin
                    state_d = test_mux_pkg::HOST_ISSUE;
                end
            end
            test_mux_pkg::HOST_ISSUE: begin
                state_d = test_mux_pkg::HOST_WAIT;
            end
            test_mux_pkg::HOST_WAIT: begin
                if (port.reg_ack) begin
                    state_d = test_mux_pkg::HOST_IDLE;
                end
            end
            default: begin
                state_d = test_mux_pkg::HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q      <= test_mux_pkg::HOST_IDLE;
            addr_q       <= 8'h00;
            wdata_q      <= 8'h00;
            is_read_q    <= 1'b0;
            rdata_q      <= 8'h00;
            pattern_en_q <= 1'b0;
            phase_q      <= 1'b0;
            done_q       <= 1'b0;
            readdata_q   <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            done_q  <= accept;
            phase_q <= pattern_en_q ? ~phase_q : 1'b0;
            if (start) begin
                wdata_q   <= avs_writedata_in[7:0];
                addr_q    <= avs_writedata_in[15:8];
                is_read_q <= avs_writedata_in[`HOST_CMD_READ_BIT];
            end
            if (state_q == test_mux_pkg::HOST_WAIT && port.reg_ack && is_read_q) begin
                rdata_q <= port.reg_rdata;
            end
            if (take_write && sel_pattern) begin
                pattern_en_q <= avs_writedata_in[`HOST_PATTERN_EN_BIT];
            end
            if (accept && avs_read_in) begin
                if (sel_status) begin
                    readdata_q <= {16'h0000, rdata_q, 7'h00, busy};
                end else if (sel_pattern) begin
                    readdata_q <= {31'h0000_0000, pattern_en_q};
                end else if (sel_cmd) begin
                    readdata_q <= {15'h0000, is_read_q, addr_q, wdata_q};
                end else begin
                    readdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    assign avs_readdata_out        = readdata_q;
    assign port.reg_addr           = addr_q;
    assign port.reg_wdata          = wdata_q;
    assign port.reg_wr             = (state_q == test_mux_pkg::HOST_ISSUE) && !is_read_q;
    assign port.reg_rd             = (state_q == test_mux_pkg::HOST_ISSUE) && is_read_q;
    assign port.data_clock_input   = phase_q;
    assign port.port_a_data_inputs = phase_q ? pattern_hi : pattern_lo;
    assign port.port_b_data_inputs = phase_q ? pattern_hi : pattern_lo;
endmodule

// [bench/lvds_test_mux_config_props.sv]
/*
 * Checker for the register port and test pins between host and device.
 * Assumes the interface signals are passed in plain, one clock domain.
 */
`timescale 1ns/1ps
`include "test_mux_regs.svh"

module lvds_test_mux_config_props (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        reg_ack,
    input  wire logic        data_clock_input,
    input  wire logic [15:0] port_b_data_inputs,
    input  wire logic        test_p,
    input  wire logic        test_n,
    input  wire logic        test_oe_n
);
    // ****
    // shadow of the mux control register
    // ****
    logic [7:0] mux_q;
    wire        mux_wr = reg_wr && (reg_addr == `MUX_CTRL_OFFSET);
    wire        mux_rd = reg_rd && (reg_addr == `MUX_CTRL_OFFSET);

    always_ff @(posedge clk_in) begin
        if (rst_in)
            mux_q <= 8'h00;
        else if (mux_wr)
            mux_q <= reg_wdata & 8'h7F;
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence mux_on_write;
        mux_wr && reg_wdata[6];
    endsequence
    sequence pins_driven;
        !test_oe_n && (test_n == ~test_p);
    endsequence

    chk_strobe_acked: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("strobe not acknowledged");
    chk_ack_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
        else $error("acknowledge without strobe");
    chk_wr_rd_apart: assert property (!(reg_wr && reg_rd))
        else $error("write and read together");
    chk_enable_drives: assert property (mux_on_write |-> ##2 pins_driven)
        else $error("enabled mux not driving pins");
    chk_pins_opposite: assert property (!test_oe_n |-> test_n == ~test_p)
        else $error("test pair not complementary");
    chk_off_undriven: assert property (!mux_q[6] && !$past(mux_q[6]) |-> test_oe_n)
        else $error("pins driven while mux off");
    chk_route_b_top: assert property ((mux_q == 8'h60) && ($past(mux_q) == 8'h60)
        |-> !test_oe_n && (test_p == $past(port_b_data_inputs[15])))
        else $error("0x60 not routing port B top bit");
    chk_route_clk_inv: assert property ((mux_q == 8'h61) && ($past(mux_q) == 8'h61)
        |-> !test_oe_n && (test_p == ~$past(data_clock_input)))
        else $error("0x61 not routing inverted clock");
    chk_mux_readback: assert property (mux_rd |=> reg_rdata == mux_q)
        else $error("mux register readback wrong");
    chk_reset_quiet: assert property ($fell(rst_in) |-> test_oe_n && !reg_ack)
        else $error("pins or ack active after reset");
endmodule

// [bench/lvds_test_mux_config_tb.sv]
/*
 * Testbench: host and device ends joined by the interface, driven over Avalon.
 * Assumes the 16-bit variant and the host's alternating pattern generator.
 */
`timescale 1ns/1ps
`include "test_mux_regs.svh"

module lvds_test_mux_config_tb;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        linearizer_disable;
    logic [2:0]  lin_gain;
    logic [3:0]  lin_up;
    logic [3:0]  lin_lo;
    logic        dio_con;
    logic        dio_mode;
    logic        win_err;
    logic [31:0] q;
    logic        e;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #4 clk_in = ~clk_in;

    test_port_if port_if();
    test_mux_host #(.RESOLUTION(16)) test_mux_host_i (.clk_in(clk_in), .rst_in(rst_in),
        .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
        .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest), .port(port_if));
    test_mux_device #(.RESOLUTION(16)) test_mux_device_i (.clk_in(clk_in), .rst_in(rst_in),
        .port(port_if), .linearizer_disable_out(linearizer_disable), .linearizer_gain_out(lin_gain),
        .linearizer_upper_voltage_out(lin_up), .linearizer_lower_voltage_out(lin_lo),
        .temp_diode_connect_out(dio_con), .temp_diode_mode_out(dio_mode),
        .window_order_error_out(win_err));
    lvds_test_mux_config_props lvds_test_mux_config_props_i (.clk_in(clk_in),
        .rst_in(rst_in), .reg_addr(port_if.reg_addr), .reg_wdata(port_if.reg_wdata),
        .reg_wr(port_if.reg_wr), .reg_rd(port_if.reg_rd), .reg_rdata(port_if.reg_rdata),
        .reg_ack(port_if.reg_ack), .data_clock_input(port_if.data_clock_input),
        .port_b_data_inputs(port_if.port_b_data_inputs), .test_p(port_if.test_p),
        .test_n(port_if.test_n), .test_oe_n(port_if.test_oe_n));

    // ****
    // tasks
    // ****
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // waitrequest seen just before the edge is what that edge samples
    task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic dev_cmd(input logic rd, input logic [7:0] a, input logic [7:0] d);
        av(1'b0, `HOST_CMD_ADDR, {15'h0, rd, a, d});
        do av(1'b1, `HOST_STATUS_ADDR, 32'h0); while (q[0] !== 1'b0);
    endtask

    task automatic dev_rd(input logic [7:0] a, input logic [7:0] exp);
        dev_cmd(1'b1, a, 8'h00);
        check(q[15:8], exp);
    endtask

    function automatic logic ref_sig(input int p, input logic s, input logic k,
                                     input logic [15:0] a, input logic [15:0] b);
        if (p < 15)
            return s ? ~a[15-p] : a[14-p];
        if (p == 15)
            return s ? ~a[0] : k;
        if (p == 16)
            return s ? ~k : b[15];
        return s ? ~b[32-p] : b[31-p];
    endfunction

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ****
    // sequence of tests
    // ****
    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        check(port_if.test_oe_n, 1'b1);
        dev_rd(`MUX_CTRL_OFFSET, 8'h00);
        dev_rd(`LIN_CTRL_OFFSET, 8'h00);
        dev_rd(`LIN_WINDOW_OFFSET, 8'h08);
        dev_rd(`DIODE_CTRL_OFFSET, 8'h00);
        check({lin_up, lin_lo}, 8'h80);
        dev_rd(8'h20, 8'h00);
        av(1'b1, 4'hC, 32'h0);
        check(q, 32'h0);
        dev_cmd(1'b0, `LIN_CTRL_OFFSET, 8'hFF);
        dev_rd(`LIN_CTRL_OFFSET, 8'h0F);
        check({linearizer_disable, lin_gain}, 4'hF);
        for (int g = 0; g < 8; g++) begin
            dev_cmd(1'b0, `LIN_CTRL_OFFSET, 8'(g * 2));
            check({linearizer_disable, lin_gain}, 4'(g));
        end
        dev_cmd(1'b0, `LIN_WINDOW_OFFSET, 8'h5C);
        dev_rd(`LIN_WINDOW_OFFSET, 8'h5C);
        check({lin_up, lin_lo}, 8'hC5);
        check(win_err, 1'b0);
        dev_cmd(1'b0, `DIODE_CTRL_OFFSET, 8'h03);
        check({dio_con, dio_mode}, 2'b11);
        dev_cmd(1'b0, `DIODE_CTRL_OFFSET, 8'h01);
        check({dio_con, dio_mode}, 2'b10);
        dev_cmd(1'b0, `DIODE_CTRL_OFFSET, 8'h00);
        check(dio_con, 1'b0);
        av(1'b0, `HOST_PATTERN_ADDR, 32'h1);
        for (int i = 0; i < 64; i++) begin
            dev_cmd(1'b0, `MUX_CTRL_OFFSET, 8'h40 | 8'(i));
            repeat (2) begin
                @(negedge clk_in);
                e = ref_sig(i / 2, i[0], port_if.data_clock_input,
                            port_if.port_a_data_inputs, port_if.port_b_data_inputs);
                @(posedge clk_in);
                #1;
                check({port_if.test_oe_n, port_if.test_n, port_if.test_p},
                      {1'b0, ~e, e});
            end
        end
        dev_rd(`MUX_CTRL_OFFSET, 8'h7F);
        dev_cmd(1'b0, `MUX_CTRL_OFFSET, 8'h3F);
        check(port_if.test_oe_n, 1'b1);
        dev_cmd(1'b0, `MUX_CTRL_OFFSET, 8'h60);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        dev_rd(`MUX_CTRL_OFFSET, 8'h00);
        check(port_if.test_oe_n, 1'b1);
        wrap_up();
    end
endmodule
